// File: verilog/ptr_consts.svh
// Constants of the pressure/temperature readout slave.
// Assumes inclusion by bare name from design files.
`ifndef PTR_CONSTS_SVH
`define PTR_CONSTS_SVH
`define PTR_SLAVE_ADDR 7'h20
`define PTR_PRES_W 14
`define PTR_TEMP_W 11
`define PTR_PRES_MIN 14'd1637
`define PTR_PRES_MAX 14'd14745
`define PTR_ZERO_PRESSURE_CODE 14'd1637
`define PTR_STAT_MSB 15
`define PTR_STAT_LSB 14
`define PTR_FETCH_BYTES 3'd4
`define PTR_SYNC_STAGES 2
`endif

// File: verilog/ptr_pkg.sv
// Types of the pressure/temperature readout slave.
// Assumes no other package.
package ptr_pkg;
  typedef enum logic [5:0] {
    PTR_IDLE = 6'h01,
    PTR_ADDR = 6'h02,
    PTR_AACK = 6'h04,
    PTR_SEND = 6'h08,
    PTR_MACK = 6'h10,
    PTR_SKIP = 6'h20
  } ptr_state_t;
endpackage

// File: verilog/ptr_sync.sv
// Two-stage synchroniser for one asynchronous level.
// Assumes the level is free of glitches shorter than a clock.
`timescale 1ns/10ps
module ptr_sync
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_q <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // ptr_sync

// File: verilog/ptr_readout.sv
// I2C slave that returns a four-byte pressure/temperature frame.
// Assumes the bus clock is well below sys_clk_i / 4 (standard mode).
`timescale 1ns/10ps
`include "ptr_consts.svh"
// Function
// (R01) Master opens with start, address, read
// (R02) Acknowledge own address before data
// (R03) Pressure [13:8] low byte0, [7:0] byte1
// (R04) Temp [10:3] byte2, [2:0] top byte3
// (R05) Byte0 bits 7:6 are status flags
// (R06) Master ACKs three bytes, NACKs fourth, stops
// (R07) Pressure unsigned 14-bit code
// (R08) Temperature unsigned 11-bit code
// (R09) Zero pressure reports the offset code
// (R10) Pressure spans 1637 to 14745
// (R11) Answer only the fixed address
// (R12) Byte3 low five bits zero
module ptr_readout #(
  parameter logic [6:0] SLAVE_ADDR = `PTR_SLAVE_ADDR
)
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [`PTR_PRES_W-1:0] pres_code_i,
  input wire logic [`PTR_TEMP_W-1:0] temp_code_i,
  input wire logic [1:0] status_i,
  input wire logic pres_zero_i,
  output logic busy_o
);
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  ptr_pkg::ptr_state_t state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic [1:0] byte_q;
  logic [31:0] frame_q;
  logic [`PTR_PRES_W-1:0] pres_clip;
  logic drive_q;
  logic nack_q;
  logic bits_seen_q;

  // Bus pins cross into the system clock
  ptr_sync u_scl
  (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(scl_i),
    .sync_o(scl_s)
  );
  ptr_sync u_sda
  (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .async_i(sda_i),
    .sync_o(sda_s)
  );

  // Synced levels one clock back
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s; // R01
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s; // R06

  // Address compare waits until a bit was clocked in
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      bits_seen_q <= 1'b0;
    else if (start_det || stop_det)
      bits_seen_q <= 1'b0;
    else if (state_q == ptr_pkg::PTR_ADDR && scl_rise)
      bits_seen_q <= 1'b1;
  end

  // Clamp into the rated code span; zero pressure forces the offset
  always_comb
  begin
    if (pres_zero_i)
      pres_clip = `PTR_ZERO_PRESSURE_CODE; // R09
    else if (pres_code_i < `PTR_PRES_MIN)
      pres_clip = `PTR_PRES_MIN; // R10
    else if (pres_code_i > `PTR_PRES_MAX)
      pres_clip = `PTR_PRES_MAX; // R10
    else
      pres_clip = pres_code_i; // R07
  end

  // Transfer sequencer: address, ack, four bytes
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= ptr_pkg::PTR_IDLE;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      byte_q <= 2'h0;
      frame_q <= 32'h0000_0000;
      drive_q <= 1'b0;
      nack_q <= 1'b0;
    end
    else if (stop_det)
    begin
      state_q <= ptr_pkg::PTR_IDLE; // R06
      drive_q <= 1'b0;
    end
    else if (start_det)
    begin
      state_q <= ptr_pkg::PTR_ADDR; // R01
      bit_q <= 3'h0;
      drive_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ptr_pkg::PTR_IDLE:
          drive_q <= 1'b0;
        ptr_pkg::PTR_ADDR:
        begin
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q <= bit_q + 3'h1;
          end
          else if (scl_fall && bit_q == 3'h0 && bits_seen_q)
          begin
            // Eight bits seen: own address with read bit set
            if (shift_q == {SLAVE_ADDR, 1'b1}) // R11
            begin
              state_q <= ptr_pkg::PTR_AACK;
              drive_q <= 1'b1; // R02
              frame_q <= {status_i, // R05
                pres_clip[13:8], // R03
                pres_clip[7:0], // R03
                temp_code_i[10:3], // R04 R08
                temp_code_i[2:0], // R04
                5'h00}; // R12
            end
            else
              state_q <= ptr_pkg::PTR_SKIP; // R11
          end
        end
        ptr_pkg::PTR_AACK:
          if (scl_fall)
          begin
            state_q <= ptr_pkg::PTR_SEND;
            byte_q <= 2'h0;
            bit_q <= 3'h0;
            shift_q <= frame_q[31:24];
            drive_q <= ~frame_q[31];
          end
        ptr_pkg::PTR_SEND:
          if (scl_fall)
          begin
            if (bit_q == 3'h7)
            begin
              state_q <= ptr_pkg::PTR_MACK;
              drive_q <= 1'b0;
            end
            else
            begin
              shift_q <= {shift_q[6:0], 1'b0};
              drive_q <= ~shift_q[6];
            end
            bit_q <= bit_q + 3'h1;
          end
        ptr_pkg::PTR_MACK:
        begin
          if (scl_rise)
            nack_q <= sda_s;
          else if (scl_fall)
          begin
            if (nack_q || byte_q == 2'h3)
            begin
              state_q <= ptr_pkg::PTR_SKIP; // R06
              drive_q <= 1'b0;
            end
            else
            begin
              state_q <= ptr_pkg::PTR_SEND;
              byte_q <= byte_q + 2'h1;
              frame_q <= {frame_q[23:0], 8'h00};
              shift_q <= frame_q[23:16];
              drive_q <= ~frame_q[23];
            end
          end
        end
        ptr_pkg::PTR_SKIP:
          drive_q <= 1'b0;
        default:
        begin
          state_q <= ptr_pkg::PTR_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_q;
  assign busy_o = (state_q != ptr_pkg::PTR_IDLE) &&
    (state_q != ptr_pkg::PTR_SKIP);
endmodule // ptr_readout

// File: testbench/ptr_readout_properties.sv
// Port checker of the readout slave.
// Assumes SCL phases far longer than the sync delay.
`timescale 1ns/10ps
module ptr_readout_chk
(
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic busy_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_stop;
    scl_i && $rose(sda_i);
  endsequence
  a_drive_busy: assert property (sda_oe_o |-> busy_o)
    else $error("sda driven while idle");
  a_rise_low: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("drive began with scl high");
  a_fall_low: assert property ($fell(sda_oe_o) |-> !scl_i)
    else $error("release with scl high");
  a_hold_high: assert property (scl_i && $past(scl_i) |->
    $stable(sda_oe_o))
    else $error("sda changed while scl high");
  a_value_zero: assert property (sda_o == 1'b0)
    else $error("open drain value not zero");
  a_stop_idle: assert property (s_stop |-> ##[1:8] !busy_o)
    else $error("busy after stop");
  a_busy_ack: assert property ($rose(busy_o) |-> !sda_oe_o [*8])
    else $error("acknowledge before address complete");
  a_end_quiet: assert property ($fell(busy_o) |-> !sda_oe_o)
    else $error("sda held after transfer");
endmodule // ptr_readout_chk
bind ptr_readout ptr_readout_chk u_chk (.sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .busy_o(busy_o));

// File: testbench/ptr_i2c_master.sv
// I2C master model: start, address, four-byte read, stop.
// Assumes SDA resolved outside with a pull-up.
`timescale 1ns/10ps
module ptr_i2c_master
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial scl_o = 1'b1;
  initial sda_o = 1'b1;
  task automatic w(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic bt(logic b, output logic r);
    w(4);
    sda_o = b;
    w(8);
    scl_o = 1'b1;
    w(12);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic fetch(logic [6:0] a, output logic [31:0] d,
    output logic ok);
    logic r;
    logic [7:0] ab;
    ab = {a, 1'b1};
    d = 32'h00000000;
    sda_o = 1'b0;
    w(12);
    scl_o = 1'b0;
    for (int i = 7; i >= 0; i--) bt(ab[i], r);
    bt(1'b1, r);
    ok = !r;
    for (int i = 0; i < 32 && ok; i++)
    begin
      bt(1'b1, r);
      d = {d[30:0], r};
      if (i % 8 == 7) bt(i == 31, r);
    end
    w(4);
    sda_o = 1'b0;
    w(8);
    scl_o = 1'b1;
    w(12);
    sda_o = 1'b1;
    w(12);
  endtask
endmodule // ptr_i2c_master

// File: testbench/pressure_temp_i2c_readout_tb_top.sv
// Bench of the readout slave with a master model.
// Assumes the default slave address.
`timescale 1ns/10ps
`include "ptr_consts.svh"
module pressure_temp_i2c_readout_tb_top;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [13:0] pres_code_i = 14'h0000;
  logic [10:0] temp_code_i = 11'h000;
  logic [1:0] status_i = 2'h0;
  logic pres_zero_i = 1'b0;
  logic sda_o, sda_oe_o, busy_o, m_scl, m_sda, sda_w;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  assign sda_w = m_sda & ~sda_oe_o;
  ptr_readout dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .scl_i(m_scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .pres_code_i(pres_code_i), .temp_code_i(temp_code_i),
    .status_i(status_i), .pres_zero_i(pres_zero_i), .busy_o(busy_o));
  ptr_i2c_master m (.clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(m_scl),
    .sda_o(m_sda));
  initial forever #20 sys_clk_i = ~sys_clk_i;
  task automatic print_verdict;
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk_i) if (++cyc == 30000)
  begin
    fail_count++;
    print_verdict();
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic t_frame(logic [13:0] p, logic [10:0] t, logic [1:0] s,
    logic z);
    logic [31:0] d;
    logic ok;
    logic [13:0] c;
    @(negedge sys_clk_i);
    {pres_code_i, temp_code_i, status_i, pres_zero_i} = {p, t, s, z};
    c = z ? `PTR_ZERO_PRESSURE_CODE : p < `PTR_PRES_MIN ? `PTR_PRES_MIN
      : p > `PTR_PRES_MAX ? `PTR_PRES_MAX : p;
    m.fetch(`PTR_SLAVE_ADDR, d, ok);
    chk("ack", 32'h1, {31'h0, ok});
    chk("frame", {s, c, t, 5'h00}, d);
    chk("busy", 32'h0, {31'h0, busy_o});
  endtask
  task automatic t_other_addr;
    logic [31:0] d;
    logic ok;
    m.fetch(7'h21, d, ok);
    chk("nack", 32'h0, {31'h0, ok});
  endtask
  initial
  begin
    repeat (8) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    t_frame(14'h1234, 11'h5A5, 2'h2, 1'b0);
    t_frame(14'h3FFF, 11'h7FF, 2'h1, 1'b0);
    t_frame(14'h0000, 11'h000, 2'h3, 1'b0);
    t_frame(14'h2000, 11'h2AA, 2'h0, 1'b1);
    t_other_addr();
    t_frame(14'h0666, 11'h401, 2'h1, 1'b0);
    print_verdict();
  end
endmodule // pressure_temp_i2c_readout_tb_top
